// ===== common/crf_defines.svh
// constants of the cpu register file: offsets, field positions, reset values
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// register offsets on the ahb-lite slave, byte addresses
`define CRF_OFS_ACCUMULATOR 32'h0000_0000
`define CRF_OFS_INDEX_POINTER 32'h0000_0004
`define CRF_OFS_STACK_POINTER 32'h0000_0008
`define CRF_OFS_PROGRAM_COUNTER 32'h0000_000C
`define CRF_OFS_CONDITION_FLAGS 32'h0000_0010
`define CRF_OFS_STATUS 32'h0000_0014

// condition flag bit positions
`define CRF_FLAG_V 7
`define CRF_FLAG_H 4
`define CRF_FLAG_I 3
`define CRF_FLAG_N 2
`define CRF_FLAG_Z 1
`define CRF_FLAG_C 0
// bits 6 and 5 always read as one
`define CRF_FLAGS_FIXED 8'h60

// reset values
`define CRF_RST_STACK_POINTER 16'h00FF
`define CRF_RST_FLAGS 8'h68
`define CRF_STACK_LOW_FILL 8'hFF

// vector locations: reset vector high byte first, interrupt table below it
`define CRF_RESET_VECTOR 16'hFFFE
`define CRF_IRQ_VECTOR_TOP 16'hFFFC

// bytes stacked on interrupt entry
`define CRF_PUSH_BYTES 3'h5
// pull targets
`define CRF_TGT_FLAGS 3'h0
`define CRF_TGT_ACC 3'h1
`define CRF_TGT_IDX_LOW 3'h2
`define CRF_TGT_PC_HIGH 3'h3
`define CRF_TGT_PC_LOW 3'h4
`define CRF_TGT_IDX_HIGH 3'h5

`endif

// ===== common/crf_pkg.sv
// types shared by the cpu register file and its users
`default_nettype none
package crf_pkg;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_RSTV = 5'b0_0001,
		ST_IDLE = 5'b0_0010,
		ST_PUSH = 5'b0_0100,
		ST_VECT = 5'b0_1000,
		ST_PULL = 5'b1_0000
	} crf_state_e;

	// micro-operations issued by the instruction sequencer
	typedef enum logic [4:0] {
		OP_NOP, OP_LDA, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA,
		OP_EOR, OP_ASLA, OP_RORA, OP_DEC_ADJUST, OP_LDHX, OP_ADD_IDX,
		OP_ADD_STACK, OP_LOAD_STACK, OP_RESET_STACK_LOW, OP_PUSH_ACC,
		OP_PUSH_IDX_HIGH, OP_PULL_ACC, OP_PULL_IDX_HIGH, OP_FETCH, OP_JMP,
		OP_BRANCH, OP_CLEAR_MASK, OP_SET_MASK, OP_INT_RETURN, OP_CLC,
		OP_SEC, OP_EA_IDX, OP_EA_STACK
	} crf_op_e;

	// branch conditions, carried in arg[11:8] of OP_BRANCH
	typedef enum logic [3:0] {
		BR_ALWAYS, BR_EQ, BR_NE, BR_CC, BR_CS, BR_GT, BR_GE, BR_LE,
		BR_LT, BR_MI, BR_PL
	} crf_cond_e;

	// operation request
	typedef struct packed {
		logic valid;
		crf_op_e code;
		logic [15:0] arg;
	} crf_op_s;

	// memory port request, read data returns one cycle after rd
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} crf_mem_s;

endpackage
`default_nettype wire

// ===== rtl/crf_regfile.sv
// cpu register file: accumulator, index, stack, program counter, flags
//
// How it works
// - eight-bit accumulator takes alu results
// - sixteen-bit index from high and low bytes
// - stack pointer resets to 00FF
// - reset-stack sets low byte FF only
// - push decrements, pull increments stack pointer
// - stack-relative address is pointer plus offset
// - counter increments on fetch, loads on jumps
// - reset loads counter from vector, high first
// - flag bits six and five read one
// - overflow flag tracks signed overflow
// - half carry from bit three, used by adjust
// - mask set blocks maskable interrupts
// - mask set after stacking, before vector fetch
// - interrupt entry never stacks index high byte
// - highest-priority pending request served first
// - interrupt return restores stacked mask
// - mask one after reset, cleared by instruction
// - negative flag copies result bit seven
// - zero flag set on zero result
// - carry from bit seven or borrow
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.svh"

module crf_regfile (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// operation requests from the instruction sequencer
	input wire crf_pkg::crf_op_s OP_REQ,
	output logic OP_READY,
	// memory port
	output crf_pkg::crf_mem_s MEM_REQ,
	input wire logic [7:0] MEM_RDATA,
	// maskable interrupt requests, bit 0 has highest priority
	input wire logic [7:0] IRQ_REQ,
	output logic [7:0] IRQ_ACK,
	// register state
	output logic [7:0] ACCUMULATOR,
	output logic [15:0] INDEX_POINTER,
	output logic [15:0] STACK_POINTER,
	output logic [15:0] PROGRAM_COUNTER,
	output logic [7:0] CONDITION_FLAGS,
	output logic [15:0] EFFECTIVE_ADDR,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP
);
	import crf_pkg::*;

	crf_state_e state_reg;
	logic [2:0] step_reg;
	logic [2:0] pull_first_reg;
	logic [2:0] pull_cnt_reg;
	logic [15:0] vec_addr_reg;
	logic [7:0] accumulator_reg;
	logic [15:0] index_pointer_reg;
	logic [15:0] stack_pointer_reg;
	logic [15:0] program_counter_reg;
	logic [7:0] condition_flags_reg;
	logic [15:0] ea_reg;
	logic [7:0] irq_ack_reg;
	logic bus_wr_pend_reg;
	logic [31:0] bus_addr_reg;
	logic [31:0] hrdata_reg;

	logic irq_any;
	logic [2:0] irq_idx;
	logic irq_take;
	logic op_go;
	logic bus_wr;
	logic pull_issue;
	logic pull_cap;
	logic [2:0] pull_tgt;
	logic pull_last;
	logic br_taken;
	logic [7:0] push_byte;
	logic [7:0] alu_res;
	logic alu_acc;
	logic alu_v;
	logic alu_h;
	logic alu_c;
	logic alu_vhc;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] m;
	logic fix_lo;
	logic fix_hi;
	logic [2:0] i_idx;

	// interrupt arbitration; scanning down lets the lowest index win
	always_comb begin
		irq_any = |IRQ_REQ;
		irq_idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			i_idx = 3'(i);
			if (IRQ_REQ[i]) begin
				irq_idx = i_idx;
			end
		end
	end

	// requests are only taken between operations, never mid-sequence
	// mask gates requests
	assign irq_take = (state_reg == ST_IDLE) && !condition_flags_reg[`CRF_FLAG_I] &&
		irq_any && !bus_wr_pend_reg;
	assign OP_READY = (state_reg == ST_IDLE) && !irq_take && !bus_wr_pend_reg;
	assign op_go = OP_REQ.valid && OP_READY;
	assign bus_wr = bus_wr_pend_reg;

	// pull sequence: issue at step s, capture the byte one step later
	assign pull_issue = (state_reg == ST_PULL) && (step_reg < pull_cnt_reg);
	assign pull_cap = (state_reg == ST_PULL) && (step_reg != 3'h0);
	assign pull_tgt = pull_first_reg + step_reg - 3'h1;
	assign pull_last = pull_cap && (step_reg == pull_cnt_reg);

	// stacked order on entry, pulled back in reverse by interrupt return
	// index high not stacked
	always_comb begin
		case (step_reg)
			3'h0: push_byte = program_counter_reg[7:0];
			3'h1: push_byte = program_counter_reg[15:8];
			3'h2: push_byte = index_pointer_reg[7:0];
			3'h3: push_byte = accumulator_reg;
			default: push_byte = condition_flags_reg;
		endcase
	end

	// branch condition evaluation
	always_comb begin
		logic n;
		logic z;
		logic v;
		logic c;
		n = condition_flags_reg[`CRF_FLAG_N];
		z = condition_flags_reg[`CRF_FLAG_Z];
		v = condition_flags_reg[`CRF_FLAG_V];
		c = condition_flags_reg[`CRF_FLAG_C];
		case (crf_cond_e'(OP_REQ.arg[11:8]))
			BR_ALWAYS: br_taken = 1'b1;
			BR_EQ: br_taken = z;
			BR_NE: br_taken = !z;
			BR_CC: br_taken = !c;
			BR_CS: br_taken = c;
			BR_GT: br_taken = !(z | (n ^ v));
			BR_GE: br_taken = !(n ^ v);
			BR_LE: br_taken = z | (n ^ v);
			BR_LT: br_taken = n ^ v;
			BR_MI: br_taken = n;
			BR_PL: br_taken = !n;
			default: br_taken = 1'b0;
		endcase
	end

	// accumulator arithmetic and logic
	always_comb begin
		m = OP_REQ.arg[7:0];
		alu_res = accumulator_reg;
		alu_acc = 1'b1;
		alu_vhc = 1'b1;
		alu_v = 1'b0;
		alu_h = condition_flags_reg[`CRF_FLAG_H];
		alu_c = condition_flags_reg[`CRF_FLAG_C];
		sum9 = 9'h000;
		nib5 = 5'h00;
		fix_lo = 1'b0;
		fix_hi = 1'b0;
		case (OP_REQ.code)
			OP_ADD, OP_ADC: begin
				sum9 = {1'b0, accumulator_reg} + {1'b0, m} +
					{8'h00, (OP_REQ.code == OP_ADC) & condition_flags_reg[`CRF_FLAG_C]};
				nib5 = {1'b0, accumulator_reg[3:0]} + {1'b0, m[3:0]} +
					{4'h0, (OP_REQ.code == OP_ADC) & condition_flags_reg[`CRF_FLAG_C]};
				alu_res = sum9[7:0];
				alu_c = sum9[8];
				alu_h = nib5[4];
				alu_v = (accumulator_reg[7] & m[7] & !sum9[7]) |
					(!accumulator_reg[7] & !m[7] & sum9[7]);
			end
			OP_SUB, OP_SBC: begin
				sum9 = {1'b0, accumulator_reg} - {1'b0, m} -
					{8'h00, (OP_REQ.code == OP_SBC) & condition_flags_reg[`CRF_FLAG_C]};
				alu_res = sum9[7:0];
				alu_c = sum9[8];
				alu_v = (accumulator_reg[7] & !m[7] & !sum9[7]) |
					(!accumulator_reg[7] & m[7] & sum9[7]);
			end
			OP_LDA: alu_res = m;
			OP_AND: alu_res = accumulator_reg & m;
			OP_ORA: alu_res = accumulator_reg | m;
			OP_EOR: alu_res = accumulator_reg ^ m;
			OP_ASLA: begin
				alu_res = {accumulator_reg[6:0], 1'b0};
				alu_c = accumulator_reg[7];
				alu_v = accumulator_reg[6] ^ accumulator_reg[7];
			end
			OP_RORA: begin
				alu_res = {condition_flags_reg[`CRF_FLAG_C], accumulator_reg[7:1]};
				alu_c = accumulator_reg[0];
				alu_v = condition_flags_reg[`CRF_FLAG_C] ^ accumulator_reg[0];
			end
			// adjust uses half carry and carry
			OP_DEC_ADJUST: begin
				fix_lo = condition_flags_reg[`CRF_FLAG_H] || (accumulator_reg[3:0] > 4'h9);
				fix_hi = condition_flags_reg[`CRF_FLAG_C] || (accumulator_reg > 8'h99);
				alu_res = accumulator_reg + {1'b0, fix_hi, fix_hi, 1'b0, 1'b0, fix_lo, fix_lo, 1'b0};
				alu_c = fix_hi;
				alu_v = condition_flags_reg[`CRF_FLAG_V];
			end
			default: begin
				alu_acc = 1'b0;
				alu_vhc = 1'b0;
			end
		endcase
	end

	// memory port, driven from the sequencer registers, and from the taken request itself for accumulator and index-high pushes
	always_comb begin
		MEM_REQ = '0;
		if (state_reg == ST_RSTV || state_reg == ST_VECT) begin
			MEM_REQ.rd = step_reg < 3'h2;
			MEM_REQ.addr = vec_addr_reg + {15'h0000, step_reg[0]};
		end else if (state_reg == ST_PUSH) begin
			MEM_REQ.wr = 1'b1;
			MEM_REQ.addr = stack_pointer_reg;
			MEM_REQ.wdata = push_byte;
		end else if (state_reg == ST_PULL) begin
			MEM_REQ.rd = pull_issue;
			MEM_REQ.addr = stack_pointer_reg + 16'h0001;
		end else if (op_go && (OP_REQ.code == OP_PUSH_ACC ||
				OP_REQ.code == OP_PUSH_IDX_HIGH)) begin
			MEM_REQ.wr = 1'b1;
			MEM_REQ.addr = stack_pointer_reg;
			MEM_REQ.wdata = (OP_REQ.code == OP_PUSH_ACC) ? accumulator_reg :
				index_pointer_reg[15:8];
		end
	end

	// sequencer: reset vector, interrupt entry, pulls
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			state_reg <= ST_RSTV;
			step_reg <= 3'h0;
			pull_first_reg <= 3'h0;
			pull_cnt_reg <= 3'h0;
			vec_addr_reg <= `CRF_RESET_VECTOR;
		end else begin
			case (state_reg)
				ST_RSTV, ST_VECT: begin
					step_reg <= step_reg + 3'h1;
					if (step_reg == 3'h2) begin
						step_reg <= 3'h0;
						state_reg <= ST_IDLE;
					end
				end
				ST_PUSH: begin
					step_reg <= step_reg + 3'h1;
					if (step_reg == `CRF_PUSH_BYTES - 3'h1) begin
						step_reg <= 3'h0;
						state_reg <= ST_VECT;
					end
				end
				ST_PULL: begin
					step_reg <= step_reg + 3'h1;
					if (pull_last) begin
						step_reg <= 3'h0;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					if (irq_take) begin
						state_reg <= ST_PUSH;
						vec_addr_reg <= `CRF_IRQ_VECTOR_TOP - {12'h000, irq_idx, 1'b0};
					end else if (op_go && OP_REQ.code == OP_INT_RETURN) begin
						state_reg <= ST_PULL;
						pull_first_reg <= `CRF_TGT_FLAGS;
						pull_cnt_reg <= `CRF_PUSH_BYTES;
					end else if (op_go && OP_REQ.code == OP_PULL_ACC) begin
						state_reg <= ST_PULL;
						pull_first_reg <= `CRF_TGT_ACC;
						pull_cnt_reg <= 3'h1;
					end else if (op_go && OP_REQ.code == OP_PULL_IDX_HIGH) begin
						state_reg <= ST_PULL;
						pull_first_reg <= `CRF_TGT_IDX_HIGH;
						pull_cnt_reg <= 3'h1;
					end
				end
			endcase
		end
	end

	// accumulator
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			accumulator_reg <= 8'h00;
		end else if (bus_wr && bus_addr_reg == `CRF_OFS_ACCUMULATOR) begin
			accumulator_reg <= HWDATA[7:0];
		end else if (pull_cap && pull_tgt == `CRF_TGT_ACC) begin
			accumulator_reg <= MEM_RDATA;
		end else if (op_go && alu_acc) begin
			accumulator_reg <= alu_res;
		end
	end

	// index pointer, high and low bytes
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			index_pointer_reg <= 16'h0000;
		end else if (bus_wr && bus_addr_reg == `CRF_OFS_INDEX_POINTER) begin
			index_pointer_reg <= HWDATA[15:0];
		end else if (pull_cap && pull_tgt == `CRF_TGT_IDX_LOW) begin
			index_pointer_reg[7:0] <= MEM_RDATA;
		end else if (pull_cap && pull_tgt == `CRF_TGT_IDX_HIGH) begin
			index_pointer_reg[15:8] <= MEM_RDATA;
		end else if (op_go && OP_REQ.code == OP_LDHX) begin
			index_pointer_reg <= OP_REQ.arg;
		end else if (op_go && OP_REQ.code == OP_ADD_IDX) begin
			index_pointer_reg <= index_pointer_reg + OP_REQ.arg;
		end
	end

	// stack pointer
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			stack_pointer_reg <= `CRF_RST_STACK_POINTER;
		end else if (bus_wr && bus_addr_reg == `CRF_OFS_STACK_POINTER) begin
			stack_pointer_reg <= HWDATA[15:0];
		end else if (state_reg == ST_PUSH || (op_go && (OP_REQ.code == OP_PUSH_ACC ||
				OP_REQ.code == OP_PUSH_IDX_HIGH))) begin
			stack_pointer_reg <= stack_pointer_reg - 16'h0001;
		end else if (pull_issue) begin
			stack_pointer_reg <= stack_pointer_reg + 16'h0001;
		end else if (op_go && OP_REQ.code == OP_RESET_STACK_LOW) begin
			stack_pointer_reg[7:0] <= `CRF_STACK_LOW_FILL;
		end else if (op_go && OP_REQ.code == OP_LOAD_STACK) begin
			stack_pointer_reg <= OP_REQ.arg;
		end else if (op_go && OP_REQ.code == OP_ADD_STACK) begin
			stack_pointer_reg <= stack_pointer_reg + OP_REQ.arg;
		end
	end

	// program counter
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			program_counter_reg <= 16'h0000;
		end else if (bus_wr && bus_addr_reg == `CRF_OFS_PROGRAM_COUNTER) begin
			program_counter_reg <= HWDATA[15:0];
		end else if ((state_reg == ST_RSTV || state_reg == ST_VECT) && step_reg == 3'h1) begin
			program_counter_reg[15:8] <= MEM_RDATA;
		end else if ((state_reg == ST_RSTV || state_reg == ST_VECT) && step_reg == 3'h2) begin
			program_counter_reg[7:0] <= MEM_RDATA;
		end else if (pull_cap && pull_tgt == `CRF_TGT_PC_HIGH) begin
			program_counter_reg[15:8] <= MEM_RDATA;
		end else if (pull_cap && pull_tgt == `CRF_TGT_PC_LOW) begin
			program_counter_reg[7:0] <= MEM_RDATA;
		end else if (op_go && OP_REQ.code == OP_FETCH) begin
			program_counter_reg <= program_counter_reg + 16'h0001;
		end else if (op_go && OP_REQ.code == OP_JMP) begin
			program_counter_reg <= OP_REQ.arg;
		end else if (op_go && OP_REQ.code == OP_BRANCH && br_taken) begin
			program_counter_reg <= program_counter_reg + {{8{OP_REQ.arg[7]}}, OP_REQ.arg[7:0]};
		end
	end

	// condition flags; the bus may not touch the mask so only software clears it
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			condition_flags_reg <= `CRF_RST_FLAGS;
		end else if (bus_wr && bus_addr_reg == `CRF_OFS_CONDITION_FLAGS) begin
			condition_flags_reg <= HWDATA[7:0] | `CRF_FLAGS_FIXED;
			// a bus write landing on the last stacking edge must not lose the mask set
			condition_flags_reg[`CRF_FLAG_I] <= condition_flags_reg[`CRF_FLAG_I] |
				(state_reg == ST_PUSH && step_reg == `CRF_PUSH_BYTES - 3'h1);
		end else if (pull_cap && pull_tgt == `CRF_TGT_FLAGS) begin
			condition_flags_reg <= MEM_RDATA | `CRF_FLAGS_FIXED;
		end else if (state_reg == ST_PUSH && step_reg == `CRF_PUSH_BYTES - 3'h1) begin
			condition_flags_reg[`CRF_FLAG_I] <= 1'b1;
		end else if (op_go) begin
			if (OP_REQ.code == OP_CLEAR_MASK) begin
				condition_flags_reg[`CRF_FLAG_I] <= 1'b0;
			end else if (OP_REQ.code == OP_SET_MASK) begin
				condition_flags_reg[`CRF_FLAG_I] <= 1'b1;
			end else if (OP_REQ.code == OP_CLC || OP_REQ.code == OP_SEC) begin
				condition_flags_reg[`CRF_FLAG_C] <= OP_REQ.code == OP_SEC;
			end else if (alu_vhc) begin
				condition_flags_reg[`CRF_FLAG_V] <= alu_v;
				condition_flags_reg[`CRF_FLAG_H] <= alu_h;
				condition_flags_reg[`CRF_FLAG_N] <= alu_res[7];
				condition_flags_reg[`CRF_FLAG_Z] <= alu_res == 8'h00;
				condition_flags_reg[`CRF_FLAG_C] <= alu_c;
			end
		end
	end

	// operand address and interrupt acknowledge
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ea_reg <= 16'h0000;
			irq_ack_reg <= 8'h00;
		end else begin
			irq_ack_reg <= irq_take ? (8'h01 << irq_idx) : 8'h00;
			if (op_go && OP_REQ.code == OP_EA_IDX) begin
				ea_reg <= index_pointer_reg + OP_REQ.arg;
			end else if (op_go && OP_REQ.code == OP_EA_STACK) begin
				ea_reg <= stack_pointer_reg + OP_REQ.arg;
			end
		end
	end

	// ahb-lite slave: zero wait states, read data captured at address phase
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			bus_wr_pend_reg <= 1'b0;
			bus_addr_reg <= 32'h0000_0000;
			hrdata_reg <= 32'h0000_0000;
		end else if (HREADY) begin
			bus_wr_pend_reg <= HSEL && HTRANS[1] && HWRITE;
			bus_addr_reg <= HADDR;
			hrdata_reg <= 32'h0000_0000;
			if (HSEL && HTRANS[1] && !HWRITE) begin
				if (HADDR == `CRF_OFS_ACCUMULATOR) begin
					hrdata_reg <= {24'h00_0000, accumulator_reg};
				end else if (HADDR == `CRF_OFS_INDEX_POINTER) begin
					hrdata_reg <= {16'h0000, index_pointer_reg};
				end else if (HADDR == `CRF_OFS_STACK_POINTER) begin
					hrdata_reg <= {16'h0000, stack_pointer_reg};
				end else if (HADDR == `CRF_OFS_PROGRAM_COUNTER) begin
					hrdata_reg <= {16'h0000, program_counter_reg};
				end else if (HADDR == `CRF_OFS_CONDITION_FLAGS) begin
					hrdata_reg <= {24'h00_0000, condition_flags_reg | `CRF_FLAGS_FIXED};
				end else if (HADDR == `CRF_OFS_STATUS) begin
					hrdata_reg <= {27'h000_0000, state_reg};
				end
			end
		end
	end

	// outputs
	assign HRDATA = hrdata_reg;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign IRQ_ACK = irq_ack_reg;
	assign ACCUMULATOR = accumulator_reg;
	assign INDEX_POINTER = index_pointer_reg;
	assign STACK_POINTER = stack_pointer_reg;
	assign PROGRAM_COUNTER = program_counter_reg;
	assign CONDITION_FLAGS = condition_flags_reg | `CRF_FLAGS_FIXED;
	assign EFFECTIVE_ADDR = ea_reg;

endmodule
`default_nettype wire

// ===== verif/crf_regfile_sva.sv
// port checker of the cpu register file, bound to its top module
`timescale 1ns/100ps
`default_nettype none

module crf_regfile_sva (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// operation port
	input wire crf_pkg::crf_op_s OP_REQ,
	input wire logic OP_READY,
	// memory and interrupts
	input wire crf_pkg::crf_mem_s MEM_REQ,
	input wire logic [7:0] IRQ_REQ,
	input wire logic [7:0] IRQ_ACK,
	// register state
	input wire logic [7:0] ACCUMULATOR,
	input wire logic [15:0] STACK_POINTER,
	input wire logic [15:0] PROGRAM_COUNTER,
	input wire logic [7:0] CONDITION_FLAGS,
	input wire logic [15:0] EFFECTIVE_ADDR
);
	import crf_pkg::*;
	logic took;
	logic in_irq;
	logic [2:0] wr_cnt;

	// an operation is taken at an edge where it is valid and ready
	assign took = OP_REQ.valid && OP_READY;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);

	// count stacking writes from the acknowledge up to the vector read
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			in_irq <= 1'b0;
			wr_cnt <= 3'h0;
		end else if (IRQ_ACK != 8'h00) begin
			in_irq <= 1'b1;
			wr_cnt <= {2'b00, MEM_REQ.wr};
		end else if (in_irq) begin
			wr_cnt <= wr_cnt + {2'b00, MEM_REQ.wr};
			in_irq <= !MEM_REQ.rd;
		end
	end

	fixed_ones_a: assert property (CONDITION_FLAGS[6:5] == 2'b11)
		else $error("flag bits 6 and 5 not one");
	push_dec_a: assert property (took && OP_REQ.code == OP_PUSH_ACC |->
		MEM_REQ.wr && MEM_REQ.addr == STACK_POINTER
		##1 STACK_POINTER == $past(STACK_POINTER) - 16'h0001)
		else $error("push did not write at pointer and step down");
	pull_inc_a: assert property (took && OP_REQ.code == OP_PULL_ACC |=>
		MEM_REQ.rd && MEM_REQ.addr == $past(STACK_POINTER) + 16'h0001
		##2 STACK_POINTER == $past(STACK_POINTER, 3) + 16'h0001)
		else $error("pull did not read above pointer and step up");
	load_flags_a: assert property (took && OP_REQ.code == OP_LDA |=>
		ACCUMULATOR == $past(OP_REQ.arg[7:0]) && CONDITION_FLAGS[2] == ACCUMULATOR[7]
		&& CONDITION_FLAGS[1] == (ACCUMULATOR == 8'h00))
		else $error("load result or negative and zero flags wrong");
	stack_low_a: assert property (took && OP_REQ.code == OP_RESET_STACK_LOW |=>
		STACK_POINTER == {$past(STACK_POINTER[15:8]), 8'hFF})
		else $error("stack low reset wrong");
	stack_addr_a: assert property (took && OP_REQ.code == OP_EA_STACK |=>
		EFFECTIVE_ADDR == $past(STACK_POINTER) + $past(OP_REQ.arg))
		else $error("stack relative address wrong");
	fetch_step_a: assert property (took && OP_REQ.code == OP_FETCH |=>
		PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 16'h0001)
		else $error("fetch did not advance counter");
	mask_block_a: assert property (CONDITION_FLAGS[3] |=> IRQ_ACK == 8'h00)
		else $error("request taken while masked");
	irq_prio_a: assert property (IRQ_ACK != 8'h00 |->
		IRQ_ACK == ($past(IRQ_REQ) & (~$past(IRQ_REQ) + 8'h01)))
		else $error("acknowledge not the highest priority request");
	entry_order_a: assert property (in_irq && MEM_REQ.rd |->
		CONDITION_FLAGS[3] && wr_cnt == 3'h5)
		else $error("vector fetched before five saves and mask set");
	entry_bound_a: assert property (IRQ_ACK != 8'h00 |-> ##[1:10] MEM_REQ.rd)
		else $error("interrupt vector never fetched");
endmodule

bind crf_regfile crf_regfile_sva i_crf_regfile_sva (
	.CLK_SYS(CLK_SYS), .NRST(NRST), .OP_REQ(OP_REQ), .OP_READY(OP_READY),
	.MEM_REQ(MEM_REQ), .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK),
	.ACCUMULATOR(ACCUMULATOR), .STACK_POINTER(STACK_POINTER),
	.PROGRAM_COUNTER(PROGRAM_COUNTER), .CONDITION_FLAGS(CONDITION_FLAGS),
	.EFFECTIVE_ADDR(EFFECTIVE_ADDR)
);

`default_nettype wire

// ===== verif/crf_regfile_test.sv
// self-checking bench of the cpu register file
`timescale 1ns/100ps
`default_nettype none
`include "crf_defines.svh"

module test_crf_regfile;
	import crf_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	crf_op_s op_req = '0;
	crf_mem_s mem_req;
	logic op_ready, hreadyout, hresp, s;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] irq_req = 8'h00;
	logic [7:0] irq_ack, acc, flags, a, b, r;
	logic [15:0] idx, sp, pc, ea, sp0, p1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, q;
	logic [7:0] mem [0:65535];
	int n_errors = 0;
	int n_tests = 0;
	int k;

	crf_regfile i_crf_regfile (
		.CLK_SYS(clk_sys), .NRST(nrst), .OP_REQ(op_req), .OP_READY(op_ready),
		.MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack),
		.ACCUMULATOR(acc), .INDEX_POINTER(idx), .STACK_POINTER(sp), .PROGRAM_COUNTER(pc),
		.CONDITION_FLAGS(flags), .EFFECTIVE_ADDR(ea), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp)
	);

	// 50 MHz system clock
	always #10 clk_sys = ~clk_sys;

	// ram with one cycle read latency; idle data toggles so stale bytes never match
	always @(posedge clk_sys) begin
		if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
		mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single ahb-lite word transfer, held until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= ad;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	// request held until taken, then one edge for the result to land
	task automatic op(input crf_op_e c, input logic [15:0] g);
		k = 0;
		@(posedge clk_sys);
		op_req <= '{1'b1, c, g};
		do begin
			@(posedge clk_sys);
			k++;
		end while (op_ready !== 1'b1 && k < 60);
		op_req.valid <= 1'b0;
		@(posedge clk_sys);
		if (k >= 60) check(32'h0, 32'h1);
	endtask

	task automatic rdy();
		k = 0;
		while (op_ready !== 1'b1 && k < 60) begin
			@(posedge clk_sys);
			k++;
		end
		check(k < 60, 1'b1);
	endtask

	// flags expected after add or subtract; bit 3 is left zero for masking
	function automatic logic [7:0] alu(input logic [7:0] x, input logic [7:0] y, input logic m);
		logic [8:0] d;
		logic v;
		logic h;
		d = m ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
		v = (m ? x[7] != y[7] : x[7] == y[7]) && (d[7] != x[7]);
		h = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F;
		return {v, 2'b11, h & !m, 1'b0, d[7], d[7:0] == 8'h00, d[8]};
	endfunction

	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200_000;
		n_errors++;
		test_done();
	end

	initial begin
		void'($urandom(32'h952d_c54a));
		for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
		mem[16'hFFFE] = 8'h12;
		mem[16'hFFFF] = 8'h34;
		mem[16'hFFF8] = 8'hAB;
		mem[16'hFFF9] = 8'hCD;
		repeat (5) @(posedge clk_sys);
		check(sp, 16'h00FF);
		check(flags, 8'h68);
		nrst <= 1'b1;
		rdy();
		check(pc, 16'h1234);
		$display("reset test done");
		ahb(1'b1, `CRF_OFS_ACCUMULATOR, 32'h0000_00A5);
		ahb(1'b0, `CRF_OFS_ACCUMULATOR, 32'h0);
		check(q, 32'h0000_00A5);
		p1 = 16'($urandom);
		ahb(1'b1, `CRF_OFS_INDEX_POINTER, {16'h0000, p1});
		ahb(1'b0, `CRF_OFS_INDEX_POINTER, 32'h0);
		check(q, {16'h0000, p1});
		ahb(1'b1, `CRF_OFS_CONDITION_FLAGS, 32'h0000_0097);
		ahb(1'b0, `CRF_OFS_CONDITION_FLAGS, 32'h0);
		check(q, 32'h0000_00FF);
		ahb(1'b0, 32'h0000_0040, 32'h0);
		check(q, 32'h0);
		check(hresp, 1'b0);
		$display("register bus test done");
		for (int i = 0; i < 10; i++) begin
			a = (i == 0) ? 8'h7F : 8'($urandom);
			b = (i < 2) ? 8'h01 : 8'($urandom);
			s = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
			if (i == 1) a = 8'h80;
			r = s ? a - b : a + b;
			op(OP_LDA, {8'h00, a});
			op(s ? OP_SUB : OP_ADD, {8'h00, b});
			check(acc, r);
			check(flags & (s ? 8'hE7 : 8'hF7), alu(a, b, s) & (s ? 8'hE7 : 8'hF7));
		end
		$display("arithmetic test done");
		op(OP_LDA, 16'h003C);
		op(OP_PUSH_ACC, 16'h0);
		check(sp, 16'h00FE);
		check(mem[16'h00FF], 8'h3C);
		op(OP_LDA, 16'h0);
		op(OP_PULL_ACC, 16'h0);
		rdy();
		check(acc, 8'h3C);
		check(sp, 16'h00FF);
		ahb(1'b1, `CRF_OFS_STACK_POINTER, 32'h0000_1234);
		op(OP_RESET_STACK_LOW, 16'h0);
		check(sp, 16'h12FF);
		op(OP_EA_STACK, 16'h0010);
		check(ea, 16'h130F);
		p1 = pc;
		op(OP_FETCH, 16'h0);
		check(pc, p1 + 16'h0001);
		op(OP_LDA, 16'h0009);
		op(OP_ADD, 16'h0009);
		op(OP_DEC_ADJUST, 16'h0);
		check(acc, 8'h18);
		p1 = pc;
		op(OP_BRANCH, {4'h0, BR_GE, 8'hF0});
		check(pc, p1 - 16'h0010);
		$display("stack and counter test done");
		ahb(1'b1, `CRF_OFS_STACK_POINTER, 32'h0000_00F0);
		ahb(1'b1, `CRF_OFS_INDEX_POINTER, 32'h0000_5A77);
		sp0 = 16'h00F0;
		p1 = pc;
		irq_req <= 8'h0C;
		repeat (6) @(posedge clk_sys);
		check(irq_ack, 8'h00);
		op(OP_CLEAR_MASK, 16'h0);
		k = 0;
		while (irq_ack === 8'h00 && k < 20) begin
			@(posedge clk_sys);
			k++;
		end
		check(irq_ack, 8'h04);
		irq_req <= 8'h00;
		rdy();
		check(pc, 16'hABCD);
		check(sp, sp0 - 16'h0005);
		check(mem[sp0], p1[7:0]);
		check(mem[sp0 - 16'h0002], 8'h77);
		check(flags[3], 1'b1);
		op(OP_INT_RETURN, 16'h0);
		rdy();
		check(sp, sp0);
		check(flags[3], 1'b0);
		check(pc, p1);
		check(idx, 16'h5A77);
		op(OP_PUSH_IDX_HIGH, 16'h0);
		op(OP_LDHX, 16'h0000);
		op(OP_PULL_IDX_HIGH, 16'h0);
		rdy();
		check(idx, 16'h5A00);
		$display("interrupt test done");
		nrst <= 1'b0;
		@(posedge clk_sys);
		check(sp, 16'h00FF);
		check(flags, 8'h68);
		nrst <= 1'b1;
		rdy();
		check(pc, 16'h1234);
		$display("second reset test done");
		test_done();
	end
endmodule

`default_nettype wire
